// ---- common/async_mem_map.svh ----
// Purpose: Constants for the asynchronous memory strobe sequencer
// Assumes: 100 MHz CPU clock
// Notes: Counts are in CPU clock periods
`ifndef ASYNC_MEM_MAP_SVH
`define ASYNC_MEM_MAP_SVH
`define CNT_W 6
`define ADDR_W 20
`define DATA_W 32
`define BE_W 4
`define RDY_LATENCY 3
`define CS_LINGER 3'h7
`define RDY_SAMPLE_BACK 6'h03
`endif

// ---- common/async_mem_pkg.sv ----
// Purpose: Types for the asynchronous memory strobe sequencer
// Assumes: Used with async_mem_map.svh
// Notes: Binary state codes
package async_mem_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_STROBE = 3'b010,
    ST_WAIT = 3'b011,
    ST_HOLD = 3'b100
  } seq_state_t;
endpackage : async_mem_pkg

// ---- core/async_memory_strobe_sequencer.sv ----
// Purpose: Setup, strobe, hold sequencing of asynchronous memory accesses
// Assumes: Counts come from chip-select space control inputs, each at least one
// Notes: Ready input is synchronised through three flip-flops
`timescale 1ns/1ps
`include "async_mem_map.svh"

module async_memory_strobe_sequencer
  import async_mem_pkg::*;
(
  input wire logic clk, // CPU clock
  input wire logic nrst, // Async reset, active low
  input wire logic req_valid, // Access request
  input wire logic req_write, // 1 write, 0 read
  input wire logic [`ADDR_W-1:0] req_addr, // Word address
  input wire logic [`BE_W-1:0] req_be, // Byte enables, active high
  input wire logic [`DATA_W-1:0] req_wdata, // Write data
  input wire logic ready_use, // Let ready input stretch the strobe
  input wire logic [`CNT_W-1:0] read_setup_cycles, // Read setup count
  input wire logic [`CNT_W-1:0] read_strobe_cycles, // Read strobe count
  input wire logic [`CNT_W-1:0] read_hold_cycles, // Read hold count
  input wire logic [`CNT_W-1:0] write_setup_cycles, // Write setup count
  input wire logic [`CNT_W-1:0] write_strobe_cycles, // Write strobe count
  input wire logic [`CNT_W-1:0] write_hold_cycles, // Write hold count
  input wire logic async_ready_in, // Ready from memory, asynchronous
  input wire logic [`DATA_W-1:0] ext_data_in, // Data bus input
  output logic req_ready, // Sequencer idle, request taken
  output logic rsp_valid, // Read data valid pulse or write done
  output logic [`DATA_W-1:0] rsp_rdata, // Captured read data
  output logic chip_select_n, // Chip select
  output logic [`BE_W-1:0] byte_lane_enable_n, // Byte enables
  output logic [`ADDR_W-1:0] ext_word_address, // Word address
  output logic [`DATA_W-1:0] ext_data_bus, // Data bus output
  output logic ext_data_oe, // Data bus output enable
  output logic async_output_enable_n, // Output enable
  output logic read_strobe_n, // Read strobe
  output logic write_strobe_n, // Write strobe
  output logic half_rate_clock_out // CPU clock divided by two
);

  seq_state_t state;
  logic is_write;
  logic [`CNT_W-1:0] cnt;
  logic [`CNT_W-1:0] strobe_len;
  logic [2:0] rdy_sync;
  logic rdy_ok;
  logic rdy_now;
  logic [2:0] linger;
  logic [`CNT_W-1:0] hold_len;
  logic strobe_end;
  logic strobe_on;
  logic [`CNT_W-1:0] low_cycles;

  // ----------------------------------------
  // Ready synchroniser
  // ----------------------------------------
  // three-stage synchroniser
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdy_sync <= 3'h7;
    end else begin
      rdy_sync <= {rdy_sync[1:0], async_ready_in};
    end
  end

  // Level accepted once stages two and three agree
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdy_ok <= 1'b1;
    end else if (rdy_sync[1] == rdy_sync[2]) begin
      rdy_ok <= rdy_sync[2];
    end
  end

  // Accepted level, usable in the very cycle the two stages agree
  assign rdy_now = (rdy_sync[1] == rdy_sync[2]) ? rdy_sync[2] : rdy_ok;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  function automatic logic [`CNT_W-1:0] pick(input logic wr, input logic [`CNT_W-1:0] r,
                                               input logic [`CNT_W-1:0] w);
    pick = wr ? w : r;
  endfunction : pick

  // Strobe ends at this edge: count run out with ready seen or not used, or wait released
  assign strobe_end = (state == ST_STROBE && cnt <= 6'h01 && !(ready_use && !rdy_now)) ||
                      (state == ST_WAIT && rdy_now);

  // Strobe low from the last setup cycle until the strobe end
  assign strobe_on = (state == ST_SETUP && cnt <= 6'h01) ||
                     ((state == ST_STROBE || state == ST_WAIT) && !strobe_end);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      cnt <= 6'h00;
      is_write <= 1'b0;
      strobe_len <= 6'h00;
      hold_len <= 6'h00;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (req_valid) begin
            is_write <= req_write;
            cnt <= pick(req_write, read_setup_cycles, write_setup_cycles);
            strobe_len <= pick(req_write, read_strobe_cycles, write_strobe_cycles);
            hold_len <= pick(req_write, read_hold_cycles, write_hold_cycles);
            state <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (cnt <= 6'h01) begin
            cnt <= strobe_len;
            state <= ST_STROBE;
          end else begin
            cnt <= cnt - 6'h01;
          end
        end
        ST_STROBE: begin
          if (strobe_end) begin
            cnt <= hold_len;
            state <= ST_HOLD;
          end else if (cnt <= 6'h01) begin
            // Ready sampled three cycles back still low: stretch
            state <= ST_WAIT;
          end else begin
            cnt <= cnt - 6'h01;
          end
        end
        ST_WAIT: begin
          // strobe ends the edge ready is accepted
          if (strobe_end) begin
            cnt <= hold_len;
            state <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (cnt <= 6'h01) begin
            state <= ST_IDLE;
          end else begin
            cnt <= cnt - 6'h01;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Pin registers
  // ----------------------------------------
  // select signals latched for the whole access
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      byte_lane_enable_n <= 4'hf;
      ext_word_address <= 20'h00000;
      ext_data_bus <= 32'h00000000;
      ext_data_oe <= 1'b0;
      async_output_enable_n <= 1'b1;
    end else if (state == ST_IDLE && req_valid) begin
      byte_lane_enable_n <= ~req_be;
      ext_word_address <= req_addr;
      ext_data_bus <= req_wdata;
      ext_data_oe <= req_write;
      async_output_enable_n <= req_write;
    end else if (state == ST_HOLD && cnt <= 6'h01) begin
      byte_lane_enable_n <= 4'hf;
      ext_data_oe <= 1'b0;
      async_output_enable_n <= 1'b1;
    end
  end

  // chip select lingers after the cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      chip_select_n <= 1'b1;
      linger <= 3'h0;
    end else if (state == ST_IDLE && req_valid) begin
      chip_select_n <= 1'b0;
      linger <= 3'h0;
    end else if (state == ST_HOLD && cnt <= 6'h01) begin
      linger <= `CS_LINGER;
    end else if (state == ST_IDLE && linger != 3'h0) begin
      linger <= linger - 3'h1;
      if (linger == 3'h1) begin
        chip_select_n <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      read_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
    end else begin
      read_strobe_n <= !(strobe_on && !is_write);
      write_strobe_n <= !(strobe_on && is_write);
    end
  end

  // Read data sampled at strobe end, completion pulse
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= 32'h00000000;
      req_ready <= 1'b1;
    end else begin
      rsp_valid <= (state == ST_HOLD && cnt <= 6'h01);
      req_ready <= (state == ST_IDLE && !req_valid) || (state == ST_HOLD && cnt <= 6'h01);
      if (strobe_end && !is_write) begin
        rsp_rdata <= ext_data_in;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      half_rate_clock_out <= 1'b0;
    end else begin
      half_rate_clock_out <= !half_rate_clock_out;
    end
  end

  // ----------------------------------------
  // Assertion helper
  // ----------------------------------------
  // Strobe-low length so far, saturating on a hung wait
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      low_cycles <= 6'h00;
    end else if (read_strobe_n && write_strobe_n) begin
      low_cycles <= 6'h00;
    end else if (low_cycles != 6'h3f) begin
      low_cycles <= low_cycles + 6'h01;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence strobe_fall_s;
    $fell(read_strobe_n) || $fell(write_strobe_n);
  endsequence

  sequence strobe_rise_s;
    $rose(read_strobe_n) || $rose(write_strobe_n);
  endsequence

  read_excl_a: assert property (@(posedge clk) disable iff (!nrst)
    !(!read_strobe_n && !write_strobe_n)) else $error("both strobes low");

  half_clk_a: assert property (@(posedge clk) disable iff (!nrst)
    $past(nrst) |-> half_rate_clock_out != $past(half_rate_clock_out)) else $error("half clock stuck");

  cs_strobe_a: assert property (@(posedge clk) disable iff (!nrst)
    strobe_fall_s |-> !chip_select_n) else $error("strobe without select");

  oe_read_a: assert property (@(posedge clk) disable iff (!nrst)
    $fell(read_strobe_n) |-> !async_output_enable_n) else $error("read without output enable");

  data_drive_a: assert property (@(posedge clk) disable iff (!nrst)
    $fell(write_strobe_n) |-> ext_data_oe) else $error("write data not driven");

  wr_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(write_strobe_n) |-> ext_data_oe) else $error("data dropped at strobe end");

  rd_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(read_strobe_n) |-> !chip_select_n && $stable(ext_word_address)) else $error("read hold broken");

  wait_low_a: assert property (@(posedge clk) disable iff (!nrst)
    state == ST_WAIT |-> !read_strobe_n || !write_strobe_n) else $error("strobe high during wait");

  rdy_end_a: assert property (@(posedge clk) disable iff (!nrst)
    state == ST_WAIT && rdy_now |=> state == ST_HOLD && read_strobe_n && write_strobe_n)
    else $error("ready not honoured");

  wait_entry_a: assert property (@(posedge clk) disable iff (!nrst)
    state == ST_STROBE && cnt <= 6'h01 && ready_use && !rdy_now |=> state == ST_WAIT &&
    (!read_strobe_n || !write_strobe_n)) else $error("late ready not stretching strobe");

  strobe_width_a: assert property (@(posedge clk) disable iff (!nrst)
    strobe_rise_s |-> $past(state) == ST_WAIT || low_cycles == strobe_len) else $error("strobe width off");

endmodule : async_memory_strobe_sequencer

// ---- tb/sram_model.sv ----
// Purpose: Asynchronous SRAM model for the strobe sequencer
// Assumes: Bench sets the wait length per access
// Notes: Undriven data lines show the inverse of their last value
`timescale 1ns/1ps
`include "async_mem_map.svh"
module sram_model (
  input wire logic clk, // CPU clock
  input wire logic chip_select_n, // Select
  input wire logic [`BE_W-1:0] byte_lane_enable_n, // Lanes
  input wire logic [`ADDR_W-1:0] ext_word_address, // Address
  input wire logic [`DATA_W-1:0] ext_data_bus, // Write data
  input wire logic async_output_enable_n, // Output enable
  input wire logic read_strobe_n, // Read strobe
  input wire logic write_strobe_n, // Write strobe
  input wire logic [3:0] wait_cycles, // Ready low span, 0 none
  output logic async_ready_in, // Ready
  output logic [`DATA_W-1:0] ext_data_in // Read data
);
  logic [`DATA_W-1:0] mem [16];
  logic [`DATA_W-1:0] last = 32'h0;
  logic [3:0] wait_cnt = 4'h0;
  logic prev_active = 1'b0;
  logic active;
  logic start;
  initial for (int i = 0; i < 16; i++) mem[i] = 32'h0;
  // Access runs from lanes enabled under select until hold end
  assign active = !chip_select_n && byte_lane_enable_n != 4'hf;
  assign start = !prev_active && active;
  // ready low from access start, settled before the sample, then held high
  assign async_ready_in = wait_cnt == 4'h0 && !(start && wait_cycles != 4'h0);
  always @(posedge clk) begin
    prev_active <= active;
    last <= ext_data_in;
    if (start) wait_cnt <= wait_cycles;
    else if (wait_cnt != 4'h0) wait_cnt <= wait_cnt - 4'h1;
  end
  assign ext_data_in = (!chip_select_n && !async_output_enable_n && !read_strobe_n) ?
    mem[ext_word_address[3:0]] : ~last;
  always @(posedge write_strobe_n)
    if (!chip_select_n)
      for (int b = 0; b < 4; b++)
        if (!byte_lane_enable_n[b]) mem[ext_word_address[3:0]][8*b +: 8] <= ext_data_bus[8*b +: 8];
endmodule : sram_model

// ---- tb/tb_top.sv ----
// Purpose: Self-checking bench for the strobe sequencer
// Assumes: 100 MHz clock, counts drawn per access
// Notes: Fixed seed; every third access is stretched by ready
`timescale 1ns/1ps
`include "async_mem_map.svh"
module tb_top;
  logic clk = 1'b0, nrst = 1'b0, req_valid = 1'b0, req_write = 1'b0, ready_use = 1'b0;
  logic go = 1'b0, half_q = 1'b0, done = 1'b1;
  logic [`ADDR_W-1:0] req_addr = 20'h0;
  logic [`BE_W-1:0] req_be = 4'hf;
  logic [`DATA_W-1:0] req_wdata = 32'h0;
  logic [`CNT_W-1:0] read_setup_cycles = 6'h1, read_strobe_cycles = 6'h3, read_hold_cycles = 6'h1;
  logic [`CNT_W-1:0] write_setup_cycles = 6'h1, write_strobe_cycles = 6'h3, write_hold_cycles = 6'h1;
  logic [3:0] wait_cycles = 4'h0;
  logic async_ready_in, req_ready, rsp_valid, chip_select_n, ext_data_oe, async_output_enable_n;
  logic read_strobe_n, write_strobe_n, half_rate_clock_out;
  logic [`DATA_W-1:0] ext_data_in, rsp_rdata, ext_data_bus;
  logic [`BE_W-1:0] byte_lane_enable_n;
  logic [`ADDR_W-1:0] ext_word_address;
  logic [`DATA_W-1:0] shadow [16];
  int err_total = 0, checks_done = 0, n_setup, n_strobe, n_hold, n_rdy, bad = 0;

  always #5 clk = ~clk;

  async_memory_strobe_sequencer u_async_memory_strobe_sequencer (.clk, .nrst, .req_valid, .req_write,
    .req_addr, .req_be, .req_wdata, .ready_use, .read_setup_cycles, .read_strobe_cycles, .read_hold_cycles,
    .write_setup_cycles, .write_strobe_cycles, .write_hold_cycles, .async_ready_in, .ext_data_in,
    .req_ready, .rsp_valid, .rsp_rdata, .chip_select_n, .byte_lane_enable_n, .ext_word_address,
    .ext_data_bus, .ext_data_oe, .async_output_enable_n, .read_strobe_n, .write_strobe_n,
    .half_rate_clock_out);
  sram_model u_sram_model (.clk, .chip_select_n, .byte_lane_enable_n, .ext_word_address, .ext_data_bus,
    .async_output_enable_n, .read_strobe_n, .write_strobe_n, .wait_cycles, .async_ready_in, .ext_data_in);

  // Phase lengths, select stability, direction and half clock
  always @(posedge clk) begin
    if (!read_strobe_n || !write_strobe_n) begin
      n_strobe++;
      if (async_ready_in) n_rdy++;
    end else if (n_strobe == 0 && !chip_select_n) n_setup++;
    else if (n_strobe != 0 && !done) n_hold++;
    if (!done && n_strobe != 0 && (ext_word_address !== req_addr || byte_lane_enable_n !== ~req_be ||
        chip_select_n !== 1'b0 || req_ready !== 1'b0 || ext_data_oe !== req_write ||
        (req_write ? ext_data_bus !== req_wdata || !read_strobe_n :
        async_output_enable_n !== 1'b0 || !write_strobe_n))) bad++;
    if (go && half_rate_clock_out === half_q) bad++;
    half_q <= half_rate_clock_out;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic access(input int i);
    int t;
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= i < 16 || $urandom_range(0, 1) == 1;
    req_addr <= 20'(i < 16 ? i : $urandom_range(0, 15));
    req_be <= i < 16 ? 4'hf : 4'($urandom_range(1, 15));
    req_wdata <= $urandom();
    // setup plus strobe at least four, strobe wide enough
    read_setup_cycles <= 6'($urandom_range(1, 6));
    read_strobe_cycles <= 6'($urandom_range(3, 8));
    read_hold_cycles <= 6'($urandom_range(1, 6));
    write_setup_cycles <= 6'($urandom_range(1, 6));
    write_strobe_cycles <= 6'($urandom_range(3, 8));
    write_hold_cycles <= 6'($urandom_range(1, 6));
    ready_use <= i % 3 != 0;
    wait_cycles <= i % 3 == 2 ? 4'hc : 4'h0;
    @(posedge clk);
    req_valid <= 1'b0;
    #1;
    n_setup = 0;
    n_strobe = 0;
    n_hold = 0;
    n_rdy = 0;
    done = 1'b0;
    for (t = 0; rsp_valid !== 1'b1 && t < 200; t++) @(posedge clk) #1;
    done = 1'b1;
    check(32'(t < 200), 32'h1);
    check(32'(req_ready), 32'h1);
    if (wait_cycles == 4'h0) check(32'(n_strobe), 32'(req_write ? write_strobe_cycles : read_strobe_cycles));
    else check(32'(n_rdy >= 3 && n_rdy <= 4), 32'h1);
    check(32'(n_setup >= (req_write ? write_setup_cycles : read_setup_cycles)), 32'h1);
    check(32'(n_hold >= (req_write ? write_hold_cycles : read_hold_cycles)), 32'h1);
    check(32'(bad), 32'h0);
    if (req_write) begin
      for (int b = 0; b < 4; b++) if (req_be[b]) shadow[req_addr[3:0]][8*b +: 8] = req_wdata[8*b +: 8];
    end else check(rsp_rdata, shadow[req_addr[3:0]]);
    for (t = 0; chip_select_n !== 1'b1 && t < 8; t++) @(posedge clk) #1;
    check(32'(chip_select_n), 32'h1);
    check(32'(rsp_valid), 32'h0);
  endtask : access

  task automatic end_of_test;
    if (err_total == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test

  initial begin
    void'($urandom(32'ha020));
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    go <= 1'b1;
    for (int i = 0; i < 40; i++) access(i);
    end_of_test();
  end

  initial begin
    #200000;
    err_total++;
    end_of_test();
  end
endmodule : tb_top
